// >>> wicd_pkg.sv
package wicd_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_UNDEF_CNT = 12'h008;
    localparam int CTRL_DSP_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int STAT_UNDEF_BIT = 8;
    localparam int UNDEF_CNT_WIDTH = 16;
    // Plain binary immediate op field, five bits.
    localparam logic [4:0] PB_ADDW = 5'h00;
    localparam logic [4:0] PB_MOVW = 5'h04;
    localparam logic [4:0] PB_SUBW = 5'h0A;
    localparam logic [4:0] PB_MOVE_UPPER_HALF = 5'h0C;
    localparam logic [4:0] PB_SIGNED_CLAMP = 5'h10;
    localparam logic [4:0] PB_SSAT16 = 5'h12;
    localparam logic [4:0] PB_SIGNED_FIELD_EXTRACT = 5'h14;
    localparam logic [4:0] PB_BFI = 5'h16;
    localparam logic [4:0] PB_UNSIGNED_CLAMP = 5'h18;
    localparam logic [4:0] PB_USAT16 = 5'h1A;
    localparam logic [4:0] PB_UNSIGNED_FIELD_EXTRACT = 5'h1C;
    localparam logic [3:0] RN_PC = 4'hF;
    localparam logic [4:0] WRN_SP = 5'h1D;
    localparam logic [6:0] BR_HINT = 7'h3A;
    localparam logic [6:0] BR_MISC = 7'h3B;
    localparam logic [6:0] BR_PERM = 7'h7F;
    localparam logic [3:0] MC_MONITOR_CLEAR = 4'h2;
    localparam logic [3:0] MC_DSB = 4'h4;
    localparam logic [3:0] MC_DMB = 4'h5;
    localparam logic [3:0] MC_ISB = 4'h6;

    typedef enum logic [5:0] {
        C_OTHER, C_UNDEF, C_PERM_UNDEF, C_ADDW, C_SUBW, C_ADR,
        C_MOVW, C_MOVE_UPPER_HALF, C_SCLAMP, C_UCLAMP, C_SCLAMP16, C_UCLAMP16,
        C_SFX, C_UFX, C_FINS, C_FCLR, C_SPW, C_SPR, C_BCOND, C_B,
        C_BL, C_NOP, C_YIELD, C_WAITEV, C_WAITIRQ, C_SENDEV, C_DBGH,
        C_HINT_NOP, C_MONCLR, C_DSYNC, C_DMEMB, C_ISYNC, C_STM_IA,
        C_LDM_IA, C_POP, C_STM_DB, C_PUSH, C_LDM_DB, C_STX_W, C_LDX_W,
        C_STDBL, C_LDDBL, C_STX_B, C_STX_H, C_LDX_B, C_LDX_H,
        C_TJ_BYTE, C_TJ_HALF, C_LDW_IMM, C_LDW_LIT, C_LDW_REG, C_LDW_USR
    } wicd_class_t;

    typedef struct packed {
        wicd_class_t cls;
        logic undef;
    } wicd_result_t;
endpackage

// >>> wicd_top.sv
`timescale 1ns/100ps
`default_nettype none
module wicd_top import wicd_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [31:0] instrWord,
    input wire logic instrValid,
    output var wicd_result_t decResult_reg,
    output var logic decValid_reg,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr
);
    // First halfword in the upper bits, second in the lower.
    wire logic [15:0] hw1 = instrWord[31:16];
    wire logic [15:0] hw2 = instrWord[15:0];
    wire logic [3:0] rnF = hw1[3:0];
    wire logic rnPc = rnF == RN_PC;
    logic [31:0] ctrl_reg;
    logic [UNDEF_CNT_WIDTH-1:0] undefCnt_reg;
    wire logic dspEnable = ctrl_reg[CTRL_DSP_BIT];

    // Space selection from the top-level opcode bits.
    wire logic is32 = (hw1[15:13] == 3'h7) && (hw1[12:11] != 2'h0);
    wire logic spPbi = is32 && hw1[12:11] == 2'h2 && hw1[9] && !hw2[15];
    wire logic spBr = is32 && hw1[12:11] == 2'h2 && hw2[15];
    wire logic spLsm = is32 && hw1[12:11] == 2'h1
        && hw1[10:9] == 2'h0 && !hw1[6];
    wire logic spDx = is32 && hw1[12:11] == 2'h1
        && hw1[10:9] == 2'h0 && hw1[6];
    wire logic spLdw = is32 && hw1[12:11] == 2'h3
        && hw1[10:9] == 2'h0 && hw1[6:4] == 3'h5;

    // Plain binary immediate group.
    wire logic [4:0] pbOp = hw1[8:4];
    wire logic satImmZero = hw2[14:12] == 3'h0 && hw2[7:6] == 2'h0;
    wire wicd_class_t ssat16Cls = !satImmZero ? C_SCLAMP
        : dspEnable ? C_SCLAMP16 : C_UNDEF;
    wire wicd_class_t usat16Cls = !satImmZero ? C_UCLAMP
        : dspEnable ? C_UCLAMP16 : C_UNDEF;
    wire wicd_class_t pbCls =
        (pbOp == PB_ADDW) ? (rnPc ? C_ADR : C_ADDW) :
        (pbOp == PB_SUBW) ? (rnPc ? C_ADR : C_SUBW) :
        (pbOp == PB_MOVW) ? C_MOVW :
        (pbOp == PB_MOVE_UPPER_HALF) ? C_MOVE_UPPER_HALF :
        (pbOp == PB_SIGNED_CLAMP) ? C_SCLAMP :
        (pbOp == PB_SSAT16) ? ssat16Cls :
        (pbOp == PB_UNSIGNED_CLAMP) ? C_UCLAMP :
        (pbOp == PB_USAT16) ? usat16Cls :
        (pbOp == PB_SIGNED_FIELD_EXTRACT) ? C_SFX :
        (pbOp == PB_UNSIGNED_FIELD_EXTRACT) ? C_UFX :
        (pbOp == PB_BFI) ? (rnPc ? C_FCLR : C_FINS) :
        C_UNDEF;

    // Hint group: only op1 of zero is a hint at all.
    wire logic [2:0] hOp1 = hw2[10:8];
    wire logic [7:0] hOp2 = hw2[7:0];
    wire wicd_class_t hintCls =
        (hOp1 != 3'h0) ? C_UNDEF :
        (hOp2 == 8'h00) ? C_NOP :
        (hOp2 == 8'h01) ? C_YIELD :
        (hOp2 == 8'h02) ? C_WAITEV :
        (hOp2 == 8'h03) ? C_WAITIRQ :
        (hOp2 == 8'h04) ? C_SENDEV :
        (hOp2[7:4] == 4'hF) ? C_DBGH :
        C_HINT_NOP;

    // Miscellaneous control group.
    wire logic [3:0] mOp = hw2[7:4];
    wire wicd_class_t miscCls =
        (mOp == MC_MONITOR_CLEAR) ? C_MONCLR :
        (mOp == MC_DSB) ? C_DSYNC :
        (mOp == MC_DMB) ? C_DMEMB :
        (mOp == MC_ISB) ? C_ISYNC :
        C_UNDEF;

    // Branches and miscellaneous control.
    wire logic [2:0] brOp1 = hw2[14:12];
    wire logic [6:0] brOp = hw1[10:4];
    wire wicd_class_t brX0Cls =
        (brOp[6:1] == 6'h1C) ? C_SPW :
        (brOp[6:1] == 6'h1F) ? C_SPR :
        (brOp == BR_HINT) ? hintCls :
        (brOp == BR_MISC) ? miscCls :
        (brOp[5:3] != 3'h7) ? C_BCOND :
        (brOp1 == 3'h2 && brOp == BR_PERM) ? C_PERM_UNDEF :
        C_UNDEF;
    wire wicd_class_t brCls =
        (!brOp1[0] && !brOp1[2]) ? brX0Cls :
        (brOp1[0] && !brOp1[2]) ? C_B :
        brOp1[0] ? C_BL :
        C_UNDEF;

    // Load and store multiple; SP writeback picks the stack forms.
    wire logic [1:0] lmOp = hw1[8:7];
    wire logic lmL = hw1[4];
    wire logic spWb = {hw1[5], rnF} == WRN_SP;
    wire wicd_class_t lmCls =
        (lmOp == 2'h1) ? (!lmL ? C_STM_IA : spWb ? C_POP : C_LDM_IA) :
        (lmOp == 2'h2) ? (lmL ? C_LDM_DB : spWb ? C_PUSH : C_STM_DB) :
        C_UNDEF;

    // Dual, exclusive and table jump group.
    wire logic [1:0] dOp1 = hw1[8:7];
    wire logic [1:0] dOp2 = hw1[5:4];
    wire logic [3:0] dOp3 = hw2[7:4];
    wire logic dxStd = (!dOp1[1] && dOp2 == 2'h2) || (dOp1[1] && !dOp2[0]);
    wire logic dxLdd = (!dOp1[1] && dOp2 == 2'h3) || (dOp1[1] && dOp2[0]);
    wire wicd_class_t dxCls =
        (dOp1 == 2'h0 && dOp2 == 2'h0) ? C_STX_W :
        (dOp1 == 2'h0 && dOp2 == 2'h1) ? C_LDX_W :
        dxStd ? C_STDBL :
        dxLdd ? C_LDDBL :
        (dOp2 == 2'h0 && dOp3 == 4'h4) ? C_STX_B :
        (dOp2 == 2'h0 && dOp3 == 4'h5) ? C_STX_H :
        (dOp2 == 2'h1 && dOp3 == 4'h4) ? C_LDX_B :
        (dOp2 == 2'h1 && dOp3 == 4'h5) ? C_LDX_H :
        (dOp2 == 2'h1 && dOp3 == 4'h0) ? C_TJ_BYTE :
        (dOp2 == 2'h1 && dOp3 == 4'h1) ? C_TJ_HALF :
        C_UNDEF;

    // Load word group; the literal form owns a base of PC only while wOp1[1] is clear.
    wire logic [1:0] wOp1 = hw1[8:7];
    wire logic [5:0] wOp2 = hw2[11:6];
    wire logic wImm00 = (wOp2[5] && wOp2[2]) || wOp2[5:2] == 4'hC;
    wire wicd_class_t lwCls =
        (rnPc && !wOp1[1]) ? C_LDW_LIT :
        (wOp1 == 2'h1) ? C_LDW_IMM :
        (wOp1 != 2'h0) ? C_UNDEF :
        (wOp2 == 6'h00) ? C_LDW_REG :
        (wOp2[5:2] == 4'hE) ? C_LDW_USR :
        wImm00 ? C_LDW_IMM :
        C_UNDEF;

    // Groups outside this decoder report C_OTHER and never undefined.
    wire wicd_class_t decCls =
        spPbi ? pbCls : spBr ? brCls : spLsm ? lmCls :
        spDx ? dxCls : spLdw ? lwCls : C_OTHER;
    wire logic decUndef = decCls == C_UNDEF
        || decCls == C_PERM_UNDEF;

    // One pipeline stage; class and flag always move together.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            decResult_reg <= '{cls: C_OTHER, undef: 1'b0};
            decValid_reg <= 1'b0;
        end else if (ce) begin
            decValid_reg <= instrValid;
            if (instrValid) begin
                decResult_reg <= '{cls: decCls, undef: decUndef};
            end
        end
    end

    // APB decode. Read data is captured in the setup cycle so prdata
    // comes from a flop; the cost is one fixed wait-free access phase.
    wire logic apbSetup = psel && !penable;
    wire logic apbDone = psel && penable && pready;
    wire logic hitCtrl = paddr == ADDR_CTRL;
    wire logic hitStat = paddr == ADDR_STAT;
    wire logic hitCnt = paddr == ADDR_UNDEF_CNT;
    wire logic addrHit = hitCtrl || hitStat || hitCnt;
    wire logic [31:0] statWord = {23'h0, decResult_reg.undef,
        2'h0, decResult_reg.cls};
    wire logic [31:0] rdMux = hitCtrl ? ctrl_reg
        : hitStat ? statWord
        : hitCnt ? {{(32-UNDEF_CNT_WIDTH){1'b0}}, undefCnt_reg}
        : 32'h0000_0000;
    wire logic wrCtrl = apbDone && pwrite && hitCtrl;
    wire logic wrCnt = apbDone && pwrite && hitCnt;
    wire logic cntInc = instrValid && decUndef;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (apbSetup) begin
                pready <= 1'b1;
                pslverr <= !addrHit;
                prdata <= rdMux;
            end else if (apbDone) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Only the DSP enable bit is writable; others read as zero.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
        end else if (ce && wrCtrl) begin
            ctrl_reg <= {31'h0, pwdata[CTRL_DSP_BIT]};
        end
    end

    // Any write to the count clears it; a new event in that cycle still counts.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            undefCnt_reg <= '0;
        end else if (ce) begin
            if (wrCnt) begin
                undefCnt_reg <= {{(UNDEF_CNT_WIDTH-1){1'b0}}, cntInc};
            end else if (cntInc && undefCnt_reg != '1) begin
                undefCnt_reg <= undefCnt_reg + 1'b1;
            end
        end
    end

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence seqTake;
        ce && instrValid;
    endsequence
    sequence seqCtrlWrite;
        ce && psel && !penable && pwrite && hitCtrl && !pwdata[CTRL_DSP_BIT]
        ##1 ce && apbDone && pwrite && hitCtrl;
    endsequence

    chk_adr_form: assert property (
        seqTake and spPbi && pbOp == PB_SUBW && rnPc
        |=> decResult_reg.cls == C_ADR && !decResult_reg.undef)
        else $error("PC-relative address not decoded");
    chk_move_top: assert property (
        seqTake and spPbi && pbOp == PB_MOVE_UPPER_HALF
        |=> decResult_reg.cls == C_MOVE_UPPER_HALF)
        else $error("upper-half move not decoded");
    chk_dual_sat: assert property (
        seqTake and spPbi && pbOp == PB_USAT16 && satImmZero
        && !dspEnable |=> decResult_reg.undef)
        else $error("dual clamp decoded with DSP disabled");
    chk_field_clear: assert property (
        seqTake and spPbi && pbOp == PB_BFI
        |=> decResult_reg.cls == ($past(rnPc) ? C_FCLR : C_FINS))
        else $error("field insert or clear wrong");
    chk_special_read: assert property (
        seqTake and spBr && brOp1 == 3'h0 && brOp[6:1] == 6'h1F
        |=> decResult_reg.cls == C_SPR)
        else $error("special register read not decoded");
    chk_perm_undef: assert property (
        seqTake and spBr && brOp1 == 3'h2 && brOp == BR_PERM
        |=> decResult_reg.cls == C_PERM_UNDEF && decResult_reg.undef)
        else $error("permanent undefined not flagged");
    chk_branch_link: assert property (
        seqTake and spBr && brOp1[2] && brOp1[0]
        |=> decResult_reg.cls == C_BL)
        else $error("branch with link not decoded");
    chk_hint_never_undef: assert property (
        seqTake and spBr && !brOp1[0] && !brOp1[2]
        && brOp == BR_HINT && hOp1 == 3'h0
        |=> !decResult_reg.undef && decValid_reg)
        else $error("hint raised undefined");
    chk_barrier_set: assert property (
        seqTake and spBr && brOp1 == 3'h0 && brOp == BR_MISC
        && mOp == MC_DMB |=> decResult_reg.cls == C_DMEMB)
        else $error("memory barrier not decoded");
    chk_stack_forms: assert property (
        seqTake and spLsm && lmOp == 2'h2 && !lmL && spWb
        |=> decResult_reg.cls == C_PUSH)
        else $error("stack push not decoded");
    chk_table_jump: assert property (
        seqTake and spDx && dOp1 == 2'h1 && dOp2 == 2'h1
        && dOp3 == 4'h1 |=> decResult_reg.cls == C_TJ_HALF)
        else $error("halfword table jump not decoded");
    chk_undef_count: assert property (
        ce && cntInc && !wrCnt && undefCnt_reg != '1
        |=> undefCnt_reg == $past(undefCnt_reg) + 1'b1)
        else $error("undefined count missed an event");
    chk_undef_flag: assert property (
        decResult_reg.undef == (decResult_reg.cls == C_UNDEF
        || decResult_reg.cls == C_PERM_UNDEF))
        else $error("undefined flag disagrees with class");

    // The checks below cover the remaining groups and the register side effects.
    chk_ctrl_write: assert property (
        seqCtrlWrite |=> !dspEnable)
        else $error("control write did not clear the extension");
    chk_wait_hint: assert property (
        seqTake and spBr && !brOp1[0] && !brOp1[2] && brOp == BR_HINT
        && hOp1 == 3'h0 && hOp2 == 8'h03 |=> decResult_reg.cls == C_WAITIRQ)
        else $error("wait for interrupt hint not decoded");
    chk_stack_pop: assert property (
        seqTake and spLsm && lmOp == 2'h1 && lmL && spWb
        |=> decResult_reg.cls == C_POP)
        else $error("stack pop not decoded");
    chk_excl_word: assert property (
        seqTake and spDx && dOp1 == 2'h0 && dOp2 == 2'h1
        |=> decResult_reg.cls == C_LDX_W)
        else $error("word exclusive load not decoded");
    chk_dbl_store: assert property (
        seqTake and spDx && dOp1[1] && !dOp2[0]
        |=> decResult_reg.cls == C_STDBL)
        else $error("doubleword store not decoded");
    chk_lit_load: assert property (
        seqTake and spLdw && rnPc && !wOp1[1]
        |=> decResult_reg.cls == C_LDW_LIT)
        else $error("literal word load not decoded");
    chk_count_clear: assert property (
        ce && wrCnt && !cntInc |=> undefCnt_reg == '0)
        else $error("undefined count not cleared by a write");
endmodule // wicd_top
`default_nettype wire

// >>> wicd_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module wicd_fetch_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [31:0] nextWord,
    input wire logic nextValid,
    output logic [31:0] instrWord,
    output logic instrValid
);
    logic [31:0] lastWord_reg;
    // The idle bus flips every cycle, so a decoder that samples it out of turn cannot lean on stale data.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lastWord_reg <= 32'h0000_0000;
        end else begin
            lastWord_reg <= nextValid ? nextWord : ~lastWord_reg;
        end
    end
    // Words reach the decode stage in the cycle they are offered.
    assign instrValid = nextValid;
    assign instrWord = nextValid ? nextWord : ~lastWord_reg;
endmodule // wicd_fetch_model
`default_nettype wire

// >>> wide_instr_class_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module wide_instr_class_decoder_tb import wicd_pkg::*; ();
    typedef struct packed {logic [31:0] w; logic [31:0] m; wicd_class_t c;} wicd_case_t;
    logic core_clk, reset, ce, psel, penable, pwrite, nextValid, instrValid, decValid, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, nextWord, instrWord, prdata, rd, wd;
    wicd_result_t decResult;
    wicd_class_t lastCls;
    int fails, samplesChecked, nUndef;
    // Fixed part, randomised don't-care bits, expected class; the undefined flag is derived.
    wicd_case_t tbl[] = '{
        '{32'hF200_0000, 32'h0407_7FFF, C_ADDW}, '{32'hF20F_0000, 32'h0400_7FFF, C_ADR},
        '{32'hF2A0_0000, 32'h0407_7FFF, C_SUBW}, '{32'hF2AF_0000, 32'h0400_7FFF, C_ADR},
        '{32'hF240_0000, 32'h040F_7FFF, C_MOVW}, '{32'hF2C0_0000, 32'h040F_7FFF, C_MOVE_UPPER_HALF},
        '{32'hF300_0000, 32'h000F_7FFF, C_SCLAMP}, '{32'hF320_0000, 32'h000F_0F1F, C_SCLAMP16},
        '{32'hF320_1000, 32'h000F_0F1F, C_SCLAMP}, '{32'hF380_0000, 32'h000F_7FFF, C_UCLAMP},
        '{32'hF3A0_0000, 32'h000F_0F1F, C_UCLAMP16}, '{32'hF340_0000, 32'h000F_7FFF, C_SFX},
        '{32'hF3C0_0000, 32'h000F_7FFF, C_UFX}, '{32'hF360_0000, 32'h0007_7FFF, C_FINS},
        '{32'hF36F_0000, 32'h0000_7FFF, C_FCLR}, '{32'hF210_0000, 32'h040F_7FFF, C_UNDEF},
        '{32'hF3E0_0000, 32'h000F_7FFF, C_UNDEF}, '{32'hF380_8000, 32'h001F_2FFF, C_SPW},
        '{32'hF3E0_8000, 32'h001F_2FFF, C_SPR}, '{32'hF000_8000, 32'h01FF_2FFF, C_BCOND},
        '{32'hF400_8000, 32'h01FF_2FFF, C_BCOND}, '{32'hF3C0_8000, 32'h000F_2FFF, C_UNDEF},
        '{32'hF7F0_8000, 32'h000F_0FFF, C_UNDEF}, '{32'hF7F0_A000, 32'h000F_0FFF, C_PERM_UNDEF},
        '{32'hF000_9000, 32'h07FF_2FFF, C_B}, '{32'hF000_D000, 32'h07FF_2FFF, C_BL},
        '{32'hF3AF_8000, 32'h0000_2000, C_NOP}, '{32'hF3AF_8001, 32'h0000_2000, C_YIELD},
        '{32'hF3AF_8002, 32'h0000_2000, C_WAITEV}, '{32'hF3AF_8003, 32'h0000_2000, C_WAITIRQ},
        '{32'hF3AF_8004, 32'h0000_2000, C_SENDEV}, '{32'hF3AF_80F0, 32'h0000_200F, C_DBGH},
        '{32'hF3AF_8005, 32'h0000_2000, C_HINT_NOP}, '{32'hF3AF_80EF, 32'h0000_2000, C_HINT_NOP},
        '{32'hF3AF_8100, 32'h0000_26FF, C_UNDEF}, '{32'hF3BF_8F2F, 32'h0000_2000, C_MONCLR},
        '{32'hF3BF_8F4F, 32'h0000_2000, C_DSYNC}, '{32'hF3BF_8F5F, 32'h0000_2000, C_DMEMB},
        '{32'hF3BF_8F6F, 32'h0000_2000, C_ISYNC}, '{32'hF3BF_8F3F, 32'h0000_2000, C_UNDEF},
        '{32'hE880_0000, 32'h002F_FFFF, C_STM_IA}, '{32'hE890_0000, 32'h000F_FFFF, C_LDM_IA},
        '{32'hE8BC_0000, 32'h0000_FFFF, C_LDM_IA}, '{32'hE8BD_0000, 32'h0000_FFFF, C_POP},
        '{32'hE910_0000, 32'h002F_FFFF, C_LDM_DB}, '{32'hE900_0000, 32'h000F_FFFF, C_STM_DB},
        '{32'hE92D_0000, 32'h0000_FFFF, C_PUSH}, '{32'hE980_0000, 32'h003F_FFFF, C_UNDEF},
        '{32'hE800_0000, 32'h003F_FFFF, C_UNDEF}, '{32'hE840_0000, 32'h000F_FFFF, C_STX_W},
        '{32'hE850_0000, 32'h000F_FFFF, C_LDX_W}, '{32'hE860_0000, 32'h008F_FFFF, C_STDBL},
        '{32'hE870_0000, 32'h008F_FFFF, C_LDDBL}, '{32'hE940_0000, 32'h00AF_FFFF, C_STDBL},
        '{32'hE950_0000, 32'h00AF_FFFF, C_LDDBL}, '{32'hE8C0_0040, 32'h000F_FF0F, C_STX_B},
        '{32'hE8C0_0050, 32'h000F_FF0F, C_STX_H}, '{32'hE8D0_0040, 32'h000F_FF0F, C_LDX_B},
        '{32'hE8D0_0050, 32'h000F_FF0F, C_LDX_H}, '{32'hE8D0_0000, 32'h000F_FF0F, C_TJ_BYTE},
        '{32'hE8D0_0010, 32'h000F_FF0F, C_TJ_HALF}, '{32'hE8D0_0030, 32'h000F_FF0F, C_UNDEF},
        '{32'hF8D0_0000, 32'h0007_FFFF, C_LDW_IMM}, '{32'hF85F_0000, 32'h0080_FFFF, C_LDW_LIT},
        '{32'h0000_0000, 32'h7FFF_FFFF, C_OTHER}, '{32'hF850_0000, 32'h0007_F03F, C_LDW_REG},
        '{32'hF850_0E00, 32'h0007_F0FF, C_LDW_USR}, '{32'hF850_0900, 32'h0007_F6FF, C_LDW_IMM},
        '{32'hF950_0000, 32'h008F_FFFF, C_UNDEF}};

    // Free-running core clock, 4 ns period.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    wicd_fetch_model fetch (.core_clk(core_clk), .reset(reset), .nextWord(nextWord), .nextValid(nextValid),
        .instrWord(instrWord), .instrValid(instrValid));
    wicd_top uut (.core_clk(core_clk), .reset(reset), .ce(ce), .instrWord(instrWord), .instrValid(instrValid),
        .decResult_reg(decResult), .decValid_reg(decValid), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // The dual saturates exist only while the extension is enabled.
    function automatic wicd_class_t exp_cls(input wicd_class_t c, input logic dsp);
        if (!dsp && (c == C_SCLAMP16 || c == C_UCLAMP16)) return C_UNDEF;
        return c;
    endfunction

    function automatic logic undef_of(input wicd_class_t c);
        return (c == C_UNDEF || c == C_PERM_UNDEF);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samplesChecked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high at a rising edge, for at most 16 edges.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic check_dec(input wicd_class_t c, input logic v);
        chk("class", c, decResult.cls);
        chk("undefined flag", undef_of(c), decResult.undef);
        chk("valid", v, decValid);
    endtask

    // Back-to-back words; each result is looked at half a cycle after the edge that took it.
    task automatic run_table(input logic dsp);
        wicd_class_t pc;
        pc = C_OTHER;
        foreach (tbl[i]) begin
            @(posedge core_clk);
            nextWord <= tbl[i].w | ($urandom() & tbl[i].m);
            nextValid <= 1'b1;
            @(negedge core_clk);
            if (i > 0) check_dec(pc, 1'b1);
            pc = exp_cls(tbl[i].c, dsp);
            nUndef += undef_of(pc);
        end
        @(posedge core_clk);
        nextValid <= 1'b0;
        @(negedge core_clk);
        check_dec(pc, 1'b1);
        @(negedge core_clk);
        check_dec(pc, 1'b0);
        lastCls = pc;
    endtask

    // Main sequence: reset values, four decode rounds with the extension toggled, register map, freeze, reset.
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        nextWord = 32'h0000_0000;
        nextValid = 1'b0;
        fails = 0;
        samplesChecked = 0;
        void'($urandom(6));
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check_dec(C_OTHER, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("control reset", CTRL_RESET, rd);
        apb(1'b0, ADDR_UNDEF_CNT, 32'h0000_0000);
        chk("count reset", 32'h0000_0000, rd);
        for (int r = 0; r < 4; r++) begin
            wd = $urandom();
            wd[CTRL_DSP_BIT] = r[0];
            apb(1'b1, ADDR_CTRL, wd);
            apb(1'b0, ADDR_CTRL, 32'h0000_0000);
            chk("control", 32'(r[0]) << CTRL_DSP_BIT, rd);
            apb(1'b1, ADDR_UNDEF_CNT, $urandom());
            nUndef = 0;
            run_table(r[0]);
            apb(1'b0, ADDR_UNDEF_CNT, 32'h0000_0000);
            chk("undefined count", nUndef, rd);
            apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
            apb(1'b0, ADDR_STAT, 32'h0000_0000);
            chk("status", (32'(undef_of(lastCls)) << STAT_UNDEF_BIT) | 32'(lastCls), rd);
            chk("status error", 1'b0, err);
        end
        // Unmapped and misaligned places answer with an error and read as zero.
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk("unmapped write error", 1'b1, err);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped read error", 1'b1, err);
        chk("unmapped read data", 32'h0000_0000, rd);
        apb(1'b0, 12'h002, 32'h0000_0000);
        chk("misaligned error", 1'b1, err);
        // With the enable low a valid word must leave the stage untouched.
        @(posedge core_clk);
        ce <= 1'b0;
        nextWord <= 32'hF7F0_A000;
        nextValid <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check_dec(lastCls, 1'b0);
        @(posedge core_clk);
        ce <= 1'b1;
        @(posedge core_clk);
        nextValid <= 1'b0;
        @(negedge core_clk);
        check_dec(C_PERM_UNDEF, 1'b1);
        // A reset in mid-run must bring the stage and both registers back to their idle values.
        @(posedge core_clk);
        reset <= 1'b1;
        @(negedge core_clk);
        check_dec(C_OTHER, 1'b0);
        @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("control after reset", CTRL_RESET, rd);
        apb(1'b0, ADDR_UNDEF_CNT, 32'h0000_0000);
        chk("count after reset", 32'h0000_0000, rd);
        end_sim();
    end
endmodule // wide_instr_class_decoder_tb
`default_nettype wire
